// >>> inc/bio_regs.vh
// Constants for the three-port bidirectional I/O block.
// Assumes an 8-bit data memory bus with byte addresses.
`ifndef BIO_REGS_VH
`define BIO_REGS_VH

// ----------------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------------
`define BIO_ADDR_FIRST_LATCH  8'h12
`define BIO_ADDR_FIRST_DIR    8'h13
`define BIO_ADDR_SECOND_LATCH 8'h14
`define BIO_ADDR_SECOND_DIR   8'h15
`define BIO_ADDR_THIRD_LATCH  8'h16
`define BIO_ADDR_THIRD_DIR    8'h17

// ----------------------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------------------
`define BIO_THIRD_W           5
`define BIO_RST_BYTE          8'hff
`define BIO_RST_THIRD         5'h1f

// ----------------------------------------------------------------------------
// Special function bit positions on the first port
// ----------------------------------------------------------------------------
`define BIO_BIT_BUZ           0
`define BIO_BIT_BUZN          1
`define BIO_BIT_LAMP          2

// ----------------------------------------------------------------------------
// Reset kinds
// ----------------------------------------------------------------------------
`define BIO_RST_KIND_FULL     1'b0
`define BIO_RST_KIND_WARM     1'b1

`endif

// >>> core/bio_pin_sync.v
// Three-stage synchroniser for a bundle of pad inputs.
// Assumes pads are asynchronous to clock; output changes once stages two and three agree.
`timescale 1ns/1ps
module bio_pin_sync #(
  parameter W = 8
) (
  input  wire         clock,
  input  wire         srst,
  input  wire [W-1:0] pad_in,
  output reg  [W-1:0] pad_sync
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  integer i;

  // Pads idle high through pull-ups, so all stages reset to ones.
  always @(posedge clock) begin
    if (srst) begin
      s1_r     <= {W{1'b1}};
      s2_r     <= {W{1'b1}};
      s3_r     <= {W{1'b1}};
      pad_sync <= {W{1'b1}};
    end else begin
      s1_r <= pad_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (i = 0; i < W; i = i + 1) begin
        if (s2_r[i] == s3_r[i]) begin
          pad_sync[i] <= s3_r[i];
        end
      end
    end
  end
endmodule // bio_pin_sync

// >>> core/bio_ports.v
// Three memory-mapped bidirectional ports with buzzer and lamp carrier sharing.
// Assumes a CPU data-memory strobe interface on clock, and generators elsewhere.
//
// Functional notes
// - Data latches decoded at 12h, 14h, 16h.
// - Direction registers decoded at 13h, 15h, 17h.
// - Pad inputs not latched; sampled at read time, party holds them stable.
// - Written latch value holds until software writes it again.
// - Direction 1 is input with pull-high; 0 drives latch as output.
// - Output driver is push-pull only; no open-drain mode.
// - Read returns pad for input bits, latch for output bits.
// - Read-modify-write reads per direction then writes the result back.
// - Each latch bit can be set or cleared individually.
// - After reset all lines pulled high except third port bits 0 and 1 float.
// - Full resets load latches and directions with all ones; warm watchdog wake leaves them unchanged.
// - Any first port bit can wake the device from halt.
// - Buzzer mode drives buzzer and complement on bits 0, 1 in output mode.
// - Bits 0/1 latches gate buzzer: 00 both, 10 buzzer and low, x1 both low.
// - Lamp carrier mode drives carrier on bit 2 in output mode.
// - With carrier selected, latch 0 drives low, latch 1 passes carrier.
`timescale 1ns/1ps
`include "bio_regs.vh"
module bio_ports (
  input  wire                    clock,
  input  wire                    srst,
  input  wire                    rst_kind,
  input  wire [7:0]              mem_addr,
  input  wire                    mem_rd,
  input  wire                    mem_wr,
  input  wire [7:0]              mem_wdata,
  input  wire                    mem_bit_set,
  input  wire                    mem_bit_clr,
  input  wire [2:0]              mem_bit_sel,
  output reg  [7:0]              mem_rdata,
  input  wire [7:0]              first_port_in,
  output wire [7:0]              first_port_out,
  output wire [7:0]              first_port_oe,
  output wire [7:0]              first_port_pullup,
  input  wire [7:0]              second_port_in,
  output wire [7:0]              second_port_out,
  output wire [7:0]              second_port_oe,
  output wire [7:0]              second_port_pullup,
  input  wire [`BIO_THIRD_W-1:0] third_port_in,
  output wire [`BIO_THIRD_W-1:0] third_port_out,
  output wire [`BIO_THIRD_W-1:0] third_port_oe,
  output wire [`BIO_THIRD_W-1:0] third_port_pullup,
  input  wire                    buzzer_mode,
  input  wire                    buzzer_output,
  input  wire                    lamp_mode,
  input  wire                    lamp_carrier_output,
  input  wire                    halted,
  output wire                    wake_request
);

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  reg  [7:0]              first_port_latch_r;
  reg  [7:0]              first_port_direction_r;
  reg  [7:0]              second_port_latch_r;
  reg  [7:0]              second_port_direction_r;
  reg  [`BIO_THIRD_W-1:0] third_port_latch_r;
  reg  [`BIO_THIRD_W-1:0] third_port_direction_r;
  reg  [7:0]              first_ref_r;
  reg  [7:0]              first_port_latch_nxt;
  reg  [7:0]              second_port_latch_nxt;
  reg  [7:0]              third_latch_wide_nxt;

  wire [7:0]              first_pad;
  wire [7:0]              second_pad;
  wire [`BIO_THIRD_W-1:0] third_pad;

  // --------------------------------------------------------------------------
  // Pad synchronisers
  // --------------------------------------------------------------------------
  bio_pin_sync #(.W(8)) u_sync_first (
    .clock    (clock),
    .srst     (srst),
    .pad_in   (first_port_in),
    .pad_sync (first_pad)
  );

  bio_pin_sync #(.W(8)) u_sync_second (
    .clock    (clock),
    .srst     (srst),
    .pad_in   (second_port_in),
    .pad_sync (second_pad)
  );

  bio_pin_sync #(.W(`BIO_THIRD_W)) u_sync_third (
    .clock    (clock),
    .srst     (srst),
    .pad_in   (third_port_in),
    .pad_sync (third_pad)
  );

  // --------------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------------
  // Pick pad for input bits and latch for output bits.
  function [7:0] view;
    input [7:0] pad;
    input [7:0] lat;
    input [7:0] dir;
    begin
      view = (pad & dir) | (lat & ~dir);
    end
  endfunction

  // Next latch value for a write, a bit set or a bit clear on one port.
  // The bit operations start from the direction-dependent view, as the CPU would.
  function [7:0] next_latch;
    input [7:0] cur;
    input [7:0] seen;
    input       hit;
    input       wr;
    input       bset;
    input       bclr;
    input [2:0] sel;
    input [7:0] wdata;
    reg   [7:0] mask;
    begin
      mask = 8'h01 << sel;
      next_latch = cur;
      if (hit && wr) begin
        next_latch = wdata;
      end else if (hit && bset) begin
        next_latch = seen | mask;
      end else if (hit && bclr) begin
        next_latch = seen & ~mask;
      end
    end
  endfunction

  // --------------------------------------------------------------------------
  // Read views
  // --------------------------------------------------------------------------
  wire [7:0] first_view  = view(first_pad, first_port_latch_r, first_port_direction_r);
  wire [7:0] second_view = view(second_pad, second_port_latch_r, second_port_direction_r);
  wire [7:0] third_view  = view({3'h0, third_pad}, {3'h0, third_port_latch_r},
                                {3'h0, third_port_direction_r});

  wire hit_first  = (mem_addr == `BIO_ADDR_FIRST_LATCH);
  wire hit_second = (mem_addr == `BIO_ADDR_SECOND_LATCH);
  wire hit_third  = (mem_addr == `BIO_ADDR_THIRD_LATCH);

  always @* begin
    first_port_latch_nxt  = next_latch(first_port_latch_r, first_view, hit_first, mem_wr,
                                       mem_bit_set, mem_bit_clr, mem_bit_sel, mem_wdata);
    second_port_latch_nxt = next_latch(second_port_latch_r, second_view, hit_second, mem_wr,
                                       mem_bit_set, mem_bit_clr, mem_bit_sel, mem_wdata);
    third_latch_wide_nxt  = next_latch({3'h0, third_port_latch_r}, third_view, hit_third,
                                       mem_wr, mem_bit_set, mem_bit_clr, mem_bit_sel,
                                       mem_wdata);
  end

  // --------------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------------
  // Warm reset is the watchdog wake from halt; it must leave the ports alone.
  always @(posedge clock) begin
    if (srst) begin
      if (rst_kind == `BIO_RST_KIND_FULL) begin
        first_port_latch_r      <= `BIO_RST_BYTE;
        first_port_direction_r  <= `BIO_RST_BYTE;
        second_port_latch_r     <= `BIO_RST_BYTE;
        second_port_direction_r <= `BIO_RST_BYTE;
        third_port_latch_r      <= `BIO_RST_THIRD;
        third_port_direction_r  <= `BIO_RST_THIRD;
      end
    end else begin
      first_port_latch_r  <= first_port_latch_nxt;
      second_port_latch_r <= second_port_latch_nxt;
      third_port_latch_r  <= third_latch_wide_nxt[`BIO_THIRD_W-1:0];
      if (mem_wr && mem_addr == `BIO_ADDR_FIRST_DIR) begin
        first_port_direction_r <= mem_wdata;
      end
      if (mem_wr && mem_addr == `BIO_ADDR_SECOND_DIR) begin
        second_port_direction_r <= mem_wdata;
      end
      if (mem_wr && mem_addr == `BIO_ADDR_THIRD_DIR) begin
        third_port_direction_r <= mem_wdata[`BIO_THIRD_W-1:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------------
  // Pads are seen live through the synchroniser at the read strobe; nothing
  // holds them, so a changing pad may read either value.
  always @(posedge clock) begin
    if (srst) begin
      mem_rdata <= 8'h00;
    end else if (mem_rd) begin
      case (mem_addr)
        `BIO_ADDR_FIRST_LATCH:  mem_rdata <= first_view;
        `BIO_ADDR_FIRST_DIR:    mem_rdata <= first_port_direction_r;
        `BIO_ADDR_SECOND_LATCH: mem_rdata <= second_view;
        `BIO_ADDR_SECOND_DIR:   mem_rdata <= second_port_direction_r;
        `BIO_ADDR_THIRD_LATCH:  mem_rdata <= third_view;
        `BIO_ADDR_THIRD_DIR:    mem_rdata <= {3'h0, third_port_direction_r};
        default:                mem_rdata <= 8'h00;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Pad drivers
  // --------------------------------------------------------------------------
  wire lat0 = first_port_latch_r[`BIO_BIT_BUZ];
  wire lat1 = first_port_latch_r[`BIO_BIT_BUZN];
  wire lat2 = first_port_latch_r[`BIO_BIT_LAMP];
  wire buz0 = ~lat0 & buzzer_output;
  wire buz1 = ~lat0 & ~lat1 & ~buzzer_output;
  wire lamp = lat2 & lamp_carrier_output;

  assign first_port_out = {first_port_latch_r[7:3],
                           lamp_mode   ? lamp : lat2,
                           buzzer_mode ? buz1 : lat1,
                           buzzer_mode ? buz0 : lat0};

  // Output enable is the inverse direction; push-pull drives both levels.
  assign first_port_oe      = ~first_port_direction_r;
  assign second_port_out    = second_port_latch_r;
  assign second_port_oe     = ~second_port_direction_r;
  assign third_port_out     = third_port_latch_r;
  assign third_port_oe      = ~third_port_direction_r;
  assign first_port_pullup  = first_port_direction_r;
  assign second_port_pullup = second_port_direction_r;
  // Third port bits 0 and 1 have no pull-up, so they float as inputs.
  assign third_port_pullup  = {third_port_direction_r[`BIO_THIRD_W-1:2], 2'b00};

  // --------------------------------------------------------------------------
  // Wake-up
  // --------------------------------------------------------------------------
  always @(posedge clock) begin
    if (srst) begin
      first_ref_r <= 8'hff;
    end else if (!halted) begin
      first_ref_r <= first_pad;
    end
  end

  // Any change on any first port bit during halt asks for wake.
  assign wake_request = halted & (first_pad != first_ref_r);

endmodule // bio_ports

// >>> tb/bio_pads.sv
// Pad model for one group of port lines.
// Assumes the block drives a line while its output enable is high.
`timescale 1ns/1ps
module bio_pads #(
  parameter W = 8
) (
  input  wire         clock,
  input  wire [W-1:0] out,
  input  wire [W-1:0] oe,
  input  wire [W-1:0] pull_on,
  input  wire [W-1:0] ext_en,
  input  wire [W-1:0] ext_val,
  output wire [W-1:0] pad
);
  // An undriven line without pull-up toggles every clock, so the synchroniser never settles on it and keeps its last value.
  reg [W-1:0] drift_r = '0;
  always @(posedge clock) drift_r <= ~drift_r;
  // The bench holds the outside drive steady over every read.
  assign pad = (oe & out) | (~oe & ext_en & ext_val) | (~oe & ~ext_en & (pull_on | drift_r));
endmodule // bio_pads

// >>> tb/bio_ports_chk.sv
// Assertions on the pins of the port block.
// Assumes one clock domain with synchronous reset srst.
`timescale 1ns/1ps
module bio_ports_chk (
  input wire       clock,
  input wire       srst,
  input wire       rst_kind,
  input wire [7:0] mem_addr,
  input wire       mem_rd,
  input wire       mem_wr,
  input wire [7:0] mem_wdata,
  input wire [7:0] mem_rdata,
  input wire [7:0] first_port_out,
  input wire [7:0] first_port_oe,
  input wire [7:0] first_port_pullup,
  input wire [7:0] second_port_out,
  input wire [4:0] third_port_pullup,
  input wire       buzzer_mode,
  input wire       lamp_mode,
  input wire       lamp_carrier_output,
  input wire       halted,
  input wire       wake_request
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  sequence s_latch_wr; mem_wr && mem_addr == 8'h12; endsequence
  sequence s_dir_wr; mem_wr && mem_addr == 8'h13; endsequence
  sequence s_third_rd; mem_rd && mem_addr[7:1] == 7'h0b; endsequence
  a_latch_write: assert property (s_latch_wr |=> first_port_out[7:3] == $past(mem_wdata[7:3]))
    else $error("latch write not on pads");
  a_dir_write: assert property (s_dir_wr |=> first_port_oe == ~$past(mem_wdata))
    else $error("direction write not on enables");
  a_pull_excl: assert property (first_port_oe == ~first_port_pullup)
    else $error("pull-up and driver overlap");
  a_third_float: assert property (third_port_pullup[1:0] == 2'h0)
    else $error("floating lines pulled");
  a_full_reset: assert property ($fell(srst) && !$past(rst_kind) |-> second_port_out == 8'hff)
    else $error("full reset left latch");
  a_buzzer_pair: assert property (buzzer_mode && first_port_oe[1:0] == 2'h3 |-> !(&first_port_out[1:0]))
    else $error("buzzer pair both high");
  a_lamp_gate: assert property (lamp_mode && first_port_oe[2] && !lamp_carrier_output |-> !first_port_out[2])
    else $error("carrier line high");
  a_unmapped_read: assert property (mem_rd && (mem_addr < 8'h12 || mem_addr > 8'h17) |=> mem_rdata == 8'h0)
    else $error("unmapped read not zero");
  a_third_upper: assert property (s_third_rd |=> mem_rdata[7:5] == 3'h0)
    else $error("third port upper bits set");
  a_rdata_hold: assert property (!mem_rd |=> $stable(mem_rdata))
    else $error("read data moved");
  a_wake_halt: assert property (!halted |-> !wake_request)
    else $error("wake while running");
endmodule // bio_ports_chk
bind bio_ports bio_ports_chk bio_ports_chk_inst (.clock(clock), .srst(srst), .rst_kind(rst_kind),
  .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
  .mem_rdata(mem_rdata), .first_port_out(first_port_out), .first_port_oe(first_port_oe),
  .first_port_pullup(first_port_pullup), .second_port_out(second_port_out),
  .third_port_pullup(third_port_pullup), .buzzer_mode(buzzer_mode), .lamp_mode(lamp_mode),
  .lamp_carrier_output(lamp_carrier_output), .halted(halted), .wake_request(wake_request));

// >>> tb/bio_ports_test.sv
// Self-checking bench for the three-port block with pad models.
// Assumes a 20 MHz clock and the block's synchronous active-high reset.
`timescale 1ns/1ps
module bio_ports_test;
  logic       clock = 1'b0, srst = 1'b1, rst_kind = 1'b0, halted = 1'b0;
  logic       mem_rd = 1'b0, mem_wr = 1'b0, mem_bit_set = 1'b0, mem_bit_clr = 1'b0;
  logic [7:0] mem_addr = 8'h0, mem_wdata = 8'h0, m, lat, dir, x;
  logic [2:0] mem_bit_sel = 3'h0;
  logic       buzzer_mode = 1'b0, buzzer_output = 1'b0, lamp_mode = 1'b0, lamp_carrier_output = 1'b0;
  logic [7:0] ext_en [3] = '{8'h0, 8'h0, 8'h1f};
  logic [7:0] ext_val [3] = '{8'h0, 8'h0, 8'h1f};
  wire  [7:0] mem_rdata, po [3], poe [3], ppu [3], pin [3];
  wire        wake_request;
  int         errors = 0, cmp_count = 0, p, k, s;
  always #25 clock = ~clock;
  bio_ports bio_ports_inst (.clock(clock), .srst(srst), .rst_kind(rst_kind), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_bit_set(mem_bit_set),
    .mem_bit_clr(mem_bit_clr), .mem_bit_sel(mem_bit_sel), .mem_rdata(mem_rdata),
    .first_port_in(pin[0]), .first_port_out(po[0]), .first_port_oe(poe[0]),
    .first_port_pullup(ppu[0]), .second_port_in(pin[1]), .second_port_out(po[1]),
    .second_port_oe(poe[1]), .second_port_pullup(ppu[1]), .third_port_in(pin[2][4:0]),
    .third_port_out(po[2][4:0]), .third_port_oe(poe[2][4:0]), .third_port_pullup(ppu[2][4:0]),
    .buzzer_mode(buzzer_mode), .buzzer_output(buzzer_output), .lamp_mode(lamp_mode),
    .lamp_carrier_output(lamp_carrier_output), .halted(halted), .wake_request(wake_request));
  for (genvar g = 0; g < 3; g++) begin : pads
    localparam int W = g == 2 ? 5 : 8;
    bio_pads #(.W(W)) bio_pads_inst (.clock(clock), .out(po[g][W-1:0]), .oe(poe[g][W-1:0]),
      .pull_on(ppu[g][W-1:0]), .ext_en(ext_en[g][W-1:0]), .ext_val(ext_val[g][W-1:0]),
      .pad(pin[g][W-1:0]));
  end
  function automatic logic [7:0] shared(input logic [2:0] l, input logic b);
    return {5'h0, l[2] & b, ~(l[0] | l[1]) & ~b, ~l[0] & b};
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Kind 0 writes, 1 sets a bit, 2 clears a bit, 3 reads; strobes last one edge.
  task automatic bus(input int kind, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    mem_addr <= a;
    mem_wdata <= d;
    mem_bit_sel <= d[2:0];
    {mem_rd, mem_bit_clr, mem_bit_set, mem_wr} <= 4'h1 << kind;
    @(posedge clock);
    {mem_rd, mem_bit_clr, mem_bit_set, mem_wr} <= 4'h0;
    #1;
  endtask
  task automatic reset(input logic kind);
    @(posedge clock);
    rst_kind <= kind;
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    #1;
  endtask
  task automatic finish_test();
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    finish_test();
  end
  initial begin
    void'($urandom(32'h384b));
    repeat (16) @(posedge clock);
    srst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      bus(3, 8'h12 + i, 8'h0);
      chk(mem_rdata, i > 3 ? 8'h1f : 8'hff);
    end
    chk(ppu[2] & 8'h1f, 8'h1c);
    repeat (40) begin
      p = $urandom_range(2);
      m = p == 2 ? 8'h1f : 8'hff;
      lat = $urandom;
      dir = $urandom;
      x = $urandom;
      @(posedge clock);
      ext_en[p] <= dir;
      ext_val[p] <= x;
      bus(0, 8'h12 + 2 * p, lat);
      bus(0, 8'h13 + 2 * p, dir);
      repeat (6) @(posedge clock);
      chk(po[p] & m, lat & m);
      chk(poe[p] & m, ~dir & m);
      bus(3, 8'h12 + 2 * p, 8'h0);
      lat = lat & ~dir | x & dir;
      chk(mem_rdata, lat & m);
      k = 1 + $urandom_range(1);
      s = $urandom_range(p == 2 ? 4 : 7);
      bus(k, 8'h12 + 2 * p, s[7:0]);
      lat[s] = k == 1;
      bus(3, 8'h12 + 2 * p, 8'h0);
      chk(mem_rdata, (lat & ~dir | x & dir) & m);
      bus(3, 8'h13 + 2 * p, 8'h0);
      chk(mem_rdata, dir & m);
    end
    bus(0, 8'h13, 8'h0);
    @(posedge clock);
    buzzer_mode <= 1'b1;
    lamp_mode <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      bus(0, 8'h12, {5'h0, i[2:0]});
      buzzer_output <= i[3];
      lamp_carrier_output <= i[3];
      @(posedge clock);
      #1;
      chk(po[0] & 8'h07, shared(i[2:0], i[3]));
    end
    bus(0, 8'h20, 8'h5a);
    bus(3, 8'h20, 8'h0);
    chk(mem_rdata, 8'h0);
    bus(0, 8'h13, 8'hff);
    ext_en[0] <= 8'hff;
    ext_val[0] <= 8'h5a;
    repeat (6) @(posedge clock);
    halted <= 1'b1;
    repeat (6) @(posedge clock);
    #1;
    chk(wake_request, 1'b0);
    ext_val[0] <= 8'h5b;
    repeat (6) @(posedge clock);
    #1;
    chk(wake_request, 1'b1);
    halted <= 1'b0;
    bus(0, 8'h14, 8'h3c);
    bus(0, 8'h15, 8'h0f);
    reset(1'b1);
    chk(po[1], 8'h3c);
    chk(poe[1], 8'hf0);
    reset(1'b0);
    chk(po[1], 8'hff);
    chk(poe[1], 8'h0);
    finish_test();
  end
endmodule // bio_ports_test
